/* File: src/instruction_format_decoder.sv */
/*
  14-bit instruction format decoder: splits words into fields, classifies
  the group, paces the four-phase instruction cycle and applies move results.
  assumes program memory presents insn_word steady at the clock edge where phase is 0.
*/
`timescale 1ns/1ps
// What this block does
// - each instruction is one 14-bit word: opcode part plus operand fields
// - every word is sorted into byte, bit, or literal and control group
// - register index addresses 128 registers, 0x00 to 0x7F
// - bit ops: position index picks a bit, register index names register
// - literal ops take an eight or eleven bit constant by instruction
// - ignored bit positions never change behaviour, zero or one
// - one cycle normally; taken skip or branch takes two, second a no-op
// - an instruction cycle is exactly four oscillator periods
// - register move copies register to target and updates the zero flag
// - accumulator move stores accumulator to register, flags unchanged
module instruction_format_decoder
  import insn_decode_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // program memory word
  input  wire logic [INSN_W-1:0]     insn_word,
  // condition from execute: skip test true or pc changed
  input  wire logic                  cond_true,
  // decoded result
  output      decoded_s              decoded,
  output      logic [1:0]            phase,
  output      logic                  cycle_end,
  output      logic [DATA_W-1:0]     acc,
  output      logic                  zero_flag,
  output      logic                  two_cycle
);

  typedef enum {ST_RUN, ST_BUBBLE} flow_e;

  typedef struct packed {
    logic [1:0]        phase;
    flow_e             flow;
    decoded_s          dec;
    logic              cyc_end;
    logic [DATA_W-1:0] acc;
    logic              zero;
    logic              two;
    logic [INSN_W-1:0] word;  // latched word, kept for the branch check
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic [DATA_W-1:0] file_rdata;
  logic              file_we;

  // =========================================================
  // no-op words carry don't-care bits; clear them so every form decodes alike
  function automatic logic [INSN_W-1:0] clean_word(input logic [INSN_W-1:0] w);
    logic [INSN_W-1:0] v;
    v = ((w & ~NOP_IGNORED) == OP_NOP) ? OP_NOP : w;
    return v;
  endfunction

  // field extraction for decode; branch classification matches the latched, cleaned word
  function automatic decoded_s decode_word(input logic [INSN_W-1:0] w);
    decoded_s d;
    d = '0;
    d.valid            = 1'b1;
    d.register_index   = w[REG_IDX_LSB +: REG_IDX_W];
    d.dest_file        = w[DEST_POS];
    d.position_index   = w[BIT_IDX_LSB +: BIT_IDX_W];
    case (w[13:12])
      GRP_BYTE: d.group = 2'(GROUP_BYTE);
      GRP_BIT:  d.group = 2'(GROUP_BIT);
      default:  d.group = 2'(GROUP_LITERAL);
    endcase
    // goto and call carry eleven bits, all other literals eight
    d.lit_is_11 = (w[13:11] == LITOP_CALL) || (w[13:11] == LITOP_GOTO);
    d.constant_operand = d.lit_is_11 ? w[LIT_LSB +: LIT11_W]
                                     : {3'h0, w[LIT_LSB +: LIT8_W]};
    d.is_movf  = (w[13:12] == GRP_BYTE) && (w[11:8] == OP_MOVF);
    // nop-space bits 6:5 are don't-care, so match on bit 7 only
    d.is_movwf = (w[13:12] == GRP_BYTE) && (w[11:8] == OP_MOVWF)
                 && w[DEST_POS];
    return d;
  endfunction

  // words whose outcome may need a second cycle
  function automatic logic may_branch(input logic [INSN_W-1:0] w);
    logic br;
    br = (w[13:11] == LITOP_CALL) || (w[13:11] == LITOP_GOTO)
         || (w[13:10] == OP_RETLW) || (w == OP_RETURN) || (w == OP_RETFIE)
         || ((w[13:12] == GRP_BIT) && ((w[11:10] == BITOP_TEST_CLR)
                                     || (w[11:10] == BITOP_TEST_SET)))
         || ((w[13:12] == GRP_BYTE) && ((w[11:8] == OP_DECFSZ)
                                     || (w[11:8] == OP_INCFSZ)));
    return br;
  endfunction

  // =========================================================
  // file register store; read address follows the latched word
  file_reg_mem #(
    .DEPTH (REG_COUNT),
    .AW    (REG_IDX_W),
    .DW    (DATA_W)
  ) i_file_reg_mem (
    .clk_sys (clk_sys),
    .we      (file_we),
    .waddr   (st_reg.dec.register_index),
    .wdata   (st_reg.acc),
    .raddr   (st_reg.dec.register_index),
    .rdata   (file_rdata)
  );

  // file write only for accumulator move on the last phase of a live cycle
  assign file_we = (st_reg.phase == PHASE_LAST) && st_reg.dec.is_movwf
                   && !st_reg.dec.is_bubble;

  // =========================================================
  // next state
  always_comb begin
    st_next         = st_reg;
    st_next.cyc_end = 1'b0;
    st_next.phase   = st_reg.phase + 2'h1;
    // latch a fresh word at phase 0, or a no-op after a taken branch
    if (st_reg.phase == 2'h0) begin
      case (st_reg.flow)
        ST_BUBBLE: begin
          st_next.dec           = decode_word(OP_NOP);
          st_next.dec.is_bubble = 1'b1;
          st_next.word          = OP_NOP;
          st_next.flow          = ST_RUN;
        end
        default: begin
          st_next.dec  = decode_word(clean_word(insn_word));
          st_next.word = clean_word(insn_word);
        end
      endcase
    end
    // end of cycle: retire results, pick one or two cycle path
    if (st_reg.phase == PHASE_LAST) begin
      st_next.cyc_end = 1'b1;
      st_next.two     = 1'b0;
      if (!st_reg.dec.is_bubble) begin
        if (st_reg.dec.is_movf) begin
          st_next.zero = (file_rdata == '0);
          if (!st_reg.dec.dest_file) begin
            st_next.acc = file_rdata;
          end
        end
        if (cond_true && may_branch(st_reg.word)) begin
          st_next.flow = ST_BUBBLE;
          st_next.two  = 1'b1;
        end
      end
    end
  end

  // =========================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '{phase: 2'h0, flow: ST_RUN, dec: '0, cyc_end: 1'b0,
                  acc: '0, zero: 1'b0, two: 1'b0, word: OP_NOP};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign decoded   = st_reg.dec;
  assign phase     = st_reg.phase;
  assign cycle_end = st_reg.cyc_end;
  assign acc       = st_reg.acc;
  assign zero_flag = st_reg.zero;
  assign two_cycle = st_reg.two;

  // =========================================================
  // checks
  a_cycle_four_phases: assert property (@(posedge clk_sys) disable iff (rst)
    cycle_end |-> ##4 cycle_end) else $error("cycle not four clocks");
  a_cycle_no_early: assert property (@(posedge clk_sys) disable iff (rst)
    cycle_end |=> !cycle_end [*3]) else $error("early cycle end");
  a_bubble_after_two: assert property (@(posedge clk_sys) disable iff (rst)
    (two_cycle && cycle_end) |-> ##1 decoded.is_bubble) else $error("no bubble");
  a_bubble_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    decoded.is_bubble |-> !file_we) else $error("bubble wrote file");
  a_bubble_keeps_acc: assert property (@(posedge clk_sys) disable iff (rst)
    (decoded.is_bubble && phase == PHASE_LAST) |=> $stable(acc) && $stable(zero_flag))
    else $error("bubble changed state");
  a_movwf_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (decoded.is_movwf && phase == PHASE_LAST) |=> $stable(zero_flag))
    else $error("acc move touched flag");
  a_movf_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (decoded.is_movf && !decoded.is_bubble && phase == PHASE_LAST)
    |=> zero_flag == ($past(file_rdata) == '0)) else $error("zero flag wrong");
  a_movf_to_acc: assert property (@(posedge clk_sys) disable iff (rst)
    (decoded.is_movf && !decoded.dest_file && !decoded.is_bubble && phase == PHASE_LAST)
    |=> acc == $past(file_rdata)) else $error("acc not loaded");
  a_lit_width: assert property (@(posedge clk_sys) disable iff (rst)
    !decoded.lit_is_11 |-> decoded.constant_operand[10:8] == 3'h0)
    else $error("short literal high bits set");
  a_bubble_is_nop: assert property (@(posedge clk_sys) disable iff (rst)
    decoded.is_bubble |-> !decoded.is_movf && !decoded.is_movwf)
    else $error("bubble carries a move");
  a_two_needs_cond: assert property (@(posedge clk_sys) disable iff (rst)
    (phase == PHASE_LAST && !cond_true) |=> !two_cycle)
    else $error("two cycles without cause");
  a_no_chained_bubble: assert property (@(posedge clk_sys) disable iff (rst)
    (decoded.is_bubble && phase == PHASE_LAST) |=> !two_cycle)
    else $error("bubble chained into another");

  // main scenarios the bench is expected to reach
  c_two_cycle: cover property (@(posedge clk_sys) two_cycle && cycle_end);
  c_movf: cover property (@(posedge clk_sys) decoded.is_movf && phase == PHASE_LAST);
  c_movwf: cover property (@(posedge clk_sys) file_we);
  c_bubble: cover property (@(posedge clk_sys) decoded.is_bubble && phase == 2'h1);
  c_long_literal: cover property (@(posedge clk_sys) decoded.lit_is_11 && phase == 2'h1);

endmodule

/* File: src/insn_decode_pkg.sv */
/*
  shared constants and carriers for the 14-bit instruction format decoder.
  assumes a single core clock; no software-visible registers.
*/
package insn_decode_pkg;

  // =========================================================
  // word and field layout
  localparam int INSN_W      = 14;
  localparam int REG_IDX_W   = 7;
  localparam int BIT_IDX_W   = 3;
  localparam int DATA_W      = 8;
  localparam int LIT8_W      = 8;
  localparam int LIT11_W     = 11;
  localparam int REG_IDX_LSB = 0;
  localparam int DEST_POS    = 7;
  localparam int BIT_IDX_LSB = 7;
  localparam int LIT_LSB     = 0;
  localparam int REG_COUNT   = 128;

  // =========================================================
  // timing
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // =========================================================
  // opcode patterns (bits 13:12 pick the group)
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [3:0] OP_MOVF  = 4'h8;  // bits 11:8 of a byte op
  localparam logic [3:0] OP_MOVWF = 4'h0;  // with bit 7 set
  localparam logic [1:0] BITOP_TEST_CLR = 2'h2;
  localparam logic [1:0] BITOP_TEST_SET = 2'h3;
  localparam logic [2:0] LITOP_CALL = 3'h4;
  localparam logic [2:0] LITOP_GOTO = 3'h5;
  localparam logic [3:0] OP_DECFSZ = 4'hB;
  localparam logic [3:0] OP_INCFSZ = 4'hF;
  localparam logic [13:0] OP_RETURN  = 14'h0008;
  localparam logic [13:0] OP_RETFIE  = 14'h0009;
  localparam logic [13:0] OP_NOP     = 14'h0000;
  localparam logic [13:0] NOP_IGNORED = 14'h0060;  // don't-care bits of the no-op word
  localparam logic [3:0]  OP_RETLW   = 4'hD;  // bits 13:10

  typedef enum {GROUP_BYTE, GROUP_BIT, GROUP_LITERAL} insn_group_e;

  // decoded fields handed to the datapath
  typedef struct packed {
    logic                 valid;
    logic [1:0]           group;
    logic                 dest_file;
    logic [REG_IDX_W-1:0] register_index;
    logic [BIT_IDX_W-1:0] position_index;
    logic [LIT11_W-1:0]   constant_operand;
    logic                 lit_is_11;
    logic                 is_movf;
    logic                 is_movwf;
    logic                 is_bubble;
  } decoded_s;

  // datapath write fields; declared here but not produced by the decoder
  typedef struct packed {
    logic              acc_we;
    logic              file_we;
    logic [DATA_W-1:0] wr_data;
    logic              zero_we;
    logic              zero_val;
  } writeback_s;

endpackage

/* File: src/file_reg_mem.sv */
/*
  small file register memory: one write port, one read port, registered read.
  assumes synchronous write and read in the core clock domain.
*/
`timescale 1ns/1ps
module file_reg_mem
  import insn_decode_pkg::*;
#(
  parameter int DEPTH = REG_COUNT,
  parameter int AW    = REG_IDX_W,
  parameter int DW    = DATA_W
) (
  // clock
  input  wire logic          clk_sys,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output      logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];

  // =========================================================
  // storage; no reset so it maps to ram
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

/* File: testbench/prog_mem_model.sv */
/*
  behavioural program memory: a queue of words handed over one per cycle.
  assumes the decoder takes a word on the edge where phase is 0.
*/
`timescale 1ns/1ps
module prog_mem_model
  import insn_decode_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // decoder phase
  input  wire logic [1:0]        phase,
  // word to the decoder
  output      logic [INSN_W-1:0] insn_word
);
  // =========================================================
  // word queue
  logic [INSN_W-1:0] words[$];
  logic [INSN_W-1:0] last_word;

  initial insn_word = OP_NOP;
  initial last_word = OP_NOP;

  // queue a word for the next take
  task automatic push(input logic [INSN_W-1:0] w);
    words.push_back(w);
    if (words.size() == 1) insn_word <= w;
  endtask

  // after a take, show the next word or an inverted copy so a stale word never looks valid
  always @(posedge clk_sys) begin
    if (!rst && phase == 2'h0 && words.size() > 0) begin
      last_word = words.pop_front();
      insn_word <= (words.size() > 0) ? words[0] : ~last_word;
    end
  end
endmodule

/* File: testbench/tb_instruction_format_decoder.sv */
/*
  self-checking bench for the instruction format decoder, one task a scenario.
  assumes prog_mem_model presents each word from phase 3, ahead of the phase 0 take.
*/
`timescale 1ns/1ps
module tb_instruction_format_decoder
  import insn_decode_pkg::*;
;
  // =========================================================
  // signals
  logic              clk_sys;
  logic              rst;
  logic              cond_true;
  logic [INSN_W-1:0] insn_word;
  decoded_s          decoded;
  decoded_s          snap;
  logic [1:0]        phase;
  logic              cycle_end;
  logic              zero_flag;
  logic              two_cycle;
  logic [DATA_W-1:0] acc;
  int                errors;
  int                checked;

  instruction_format_decoder i_instruction_format_decoder (.clk_sys(clk_sys), .rst(rst),
    .insn_word(insn_word), .cond_true(cond_true), .decoded(decoded), .phase(phase),
    .cycle_end(cycle_end), .acc(acc), .zero_flag(zero_flag), .two_cycle(two_cycle));
  prog_mem_model i_prog_mem_model (.clk_sys(clk_sys), .rst(rst), .phase(phase),
    .insn_word(insn_word));

  // 250 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // =========================================================
  // helpers
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // push a word in phase 3 so it is taken at the next phase 0; returns in phase 1
  task automatic issue(input logic [INSN_W-1:0] w);
    int n;
    n = 0;
    #1;
    while (phase !== 2'h3 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    i_prog_mem_model.push(w);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // from phase 1, let the phase 3 write edge land
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // =========================================================
  // scenarios
  task automatic t_timing;
    int ends;
    ends = 0;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      if (cycle_end === 1'b1) begin
        ends++;
        chk(phase, 2'h0);
      end
    end
    chk(ends, 10);
  endtask

  task automatic t_moves;
    issue(14'h00FF);
    chk({decoded.valid, decoded.group, decoded.is_movwf, decoded.register_index},
        {1'b1, 2'h0, 1'b1, 7'h7F});
    issue(14'h0080);
    issue(14'h08FF);
    chk({decoded.is_movf, decoded.dest_file}, 2'h3);
    settle;
    chk({acc, zero_flag}, {8'h00, 1'b1});
    issue(14'h0080);
    settle;
    chk(zero_flag, 1'b1);
    issue(14'h0800);
    chk({decoded.is_movf, decoded.dest_file, decoded.register_index}, 9'h100);
    settle;
    chk({acc, zero_flag}, {8'h00, 1'b1});
  endtask

  task automatic t_fields;
    issue(14'h12AA);
    chk({decoded.group, decoded.position_index, decoded.register_index},
        {2'h1, 3'h5, 7'h2A});
    issue(14'h2ABC);
    chk({decoded.group, decoded.lit_is_11, decoded.constant_operand},
        {2'h2, 1'b1, 11'h2BC});
    issue(14'h30A5);
    chk({decoded.group, decoded.lit_is_11, decoded.constant_operand[7:0]},
        {2'h2, 1'b0, 8'hA5});
    chk({two_cycle, decoded.is_bubble}, 2'h0);
    issue(OP_NOP);
    snap = decoded;
    issue(14'h0060);
    chk(decoded, snap);
  endtask

  // a taken branch must swallow the following movf from an unwritten register
  task automatic t_branch;
    @(posedge clk_sys);
    cond_true <= 1'b1;
    issue(14'h30A5);
    issue(14'h0800);
    chk({two_cycle, decoded.is_bubble}, 2'h0);
    issue(14'h2ABC);
    issue(14'h0855);
    chk({two_cycle, decoded.is_bubble}, 2'h3);
    issue(14'h1800);
    chk({two_cycle, decoded.is_bubble, decoded.group}, {2'h0, 2'h1});
    issue(14'h0B55);
    chk({two_cycle, decoded.is_bubble}, 2'h3);
    @(posedge clk_sys);
    cond_true <= 1'b0;
    settle;
    chk({acc, zero_flag}, {8'h00, 1'b1});
  endtask

  // =========================================================
  // verdict
  task automatic wrap_up;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #20000;
    errors++;
    wrap_up;
  end

  initial begin
    rst = 1'b1;
    cond_true = 1'b0;
    errors = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_timing;
    t_moves;
    t_fields;
    t_branch;
    wrap_up;
  end
endmodule
